/* sdm_pkg.sv */
`default_nettype none
package sdm_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int SAMP_W    = 16;
  localparam int MAG_W     = 12;
  localparam int BIN_W     = 5;
  localparam int NBINS     = 32;
  localparam int ROW_W     = 4;
  localparam int PIX_AW    = BIN_W + ROW_W;
  localparam int NPIX      = NBINS * (1 << ROW_W);
  localparam int CNT_W     = 8;
  localparam int ACQ_AW    = 8;
  localparam int ACQ_DEPTH = 1 << ACQ_AW;

  // ----------------------------------------------------------------
  // Values and timing
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0]  CNT_MAX    = 8'hFF;
  localparam logic [CNT_W-1:0]  CNT_ZERO   = 8'h00;
  localparam int                DECAY_SH   = 2;
  localparam logic [MAG_W-1:0]  MASK_RESET = 12'hFFF;
  localparam logic [MAG_W-1:0]  MAG_MAX    = 12'hFFF;
  localparam logic [PIX_AW-1:0] PIX_LAST   = 9'h1FF;
  localparam logic [ACQ_AW-1:0] PTR_ONE    = 8'h01;
  localparam logic [ACQ_AW-1:0] PTR_ZERO   = 8'h00;
  localparam logic [BIN_W-1:0]  BIN_ZERO   = 5'h00;
  localparam int CLK_HZ           = 50_000_000;
  localparam int SPECTRA_PER_SEC  = 292_969;
  // Least cycles per spectrum at the top rate; must cover NBINS
  localparam int SPEC_CYCLES      = CLK_HZ / SPECTRA_PER_SEC;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PERS_MIN, PERS_HIGH, PERS_INF} sdm_pers_t;
  typedef enum logic {TRIG_MASK, TRIG_POWER} sdm_trig_mode_t;
  typedef enum logic [2:0] {ACQ_IDLE, ACQ_PRE, ACQ_ARMED, ACQ_POST, ACQ_DONE} sdm_acq_t;

  typedef struct packed {
    logic             valid;
    logic             last;
    logic [BIN_W-1:0] bin;
    logic [MAG_W-1:0] mag;
  } sdm_bin_t;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } sdm_colour_t;

  typedef struct packed {
    logic              valid;
    logic [PIX_AW-1:0] addr;
    sdm_colour_t       colour;
  } sdm_pixel_t;

endpackage

`default_nettype wire

/* sdm_density_spectrum_engine.sv */
`timescale 1ns/1ns
`default_nettype none

// Operation
// RULE1 - Every converted sample is forwarded and stored each clock, never paused. The code stops storing samples in ACQ_DONE.
// RULE2 - Spectra are taken gapless, up to 292,969 per second.
// RULE3 - Each spectrum bin is rasterized into the virtual screen, one pixel per cycle.
// RULE4 - Every pixel counter increments when a trace lands on it.
// RULE5 - On display ready, each count maps to colour, blue few to red many.
// RULE6 - Minimum persistence zeroes all counters before the next spectra accumulate. The code skips the clear when a bin hits the pixel being scanned.
// RULE7 - High persistence divides counts down so old spectra fade. The code subtracts count >> 2 per scan, so counts of 1 to 3 never fade.
// RULE8 - Infinite persistence never decays nor clears counters.
// RULE9 - Mask mode compares every bin to the mask, triggers on entry.
// RULE10 - Mask trigger reacts only at masked frequencies, ignoring signals elsewhere.
// RULE11 - Power mode triggers on any bin above the threshold.
// RULE12 - Acquisition memory is a circular buffer overwriting the oldest samples.
// RULE13 - Trigger records the current write position as trigger location.
// RULE14 - After trigger, acquisition continues for the post-trigger depth, then stops.
// RULE15 - Autodraw builds the mask from a trace plus frequency and amplitude offsets.
// RULE16 - Pixel counters saturate instead of wrapping.
// RULE17 - Triggers during pre-trigger fill or post-trigger fill are ignored.
module sdm_density_spectrum_engine
  import sdm_pkg::*;
(
  input  wire logic                  sys_clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic [SAMP_W-1:0]     adc_sample_i,
  input  wire sdm_bin_t              spec_bin_i,
  input  wire sdm_pers_t             pers_mode_i,
  input  wire logic                  disp_ready_i,
  input  wire sdm_trig_mode_t        trig_mode_i,
  input  wire logic [MAG_W-1:0]      power_thresh_i,
  input  wire logic                  mask_wr_i,
  input  wire logic [BIN_W-1:0]      mask_bin_i,
  input  wire logic [MAG_W-1:0]      mask_level_i,
  input  wire logic                  autodraw_i,
  input  wire logic signed [BIN_W:0] auto_freq_off_i,
  input  wire logic signed [MAG_W:0] auto_amp_off_i,
  input  wire logic                  arm_i,
  input  wire logic [ACQ_AW-1:0]     pre_depth_i,
  input  wire logic [ACQ_AW-1:0]     post_depth_i,
  input  wire logic [ACQ_AW-1:0]     acq_rd_addr_i,
  output logic [SAMP_W-1:0]          engine_sample_o,
  output sdm_pixel_t                 pixel_o,
  output logic                       scan_busy_o,
  output logic                       trig_o,
  output logic [ACQ_AW-1:0]          trig_pos_o,
  output logic [ACQ_AW-1:0]          wr_ptr_o,
  output logic                       acq_done_o,
  output logic [SAMP_W-1:0]          acq_rd_data_o
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [CNT_W-1:0]  pix_q  [NPIX];
  logic [MAG_W-1:0]  mask_q [NBINS];
  logic [SAMP_W-1:0] acq_q  [ACQ_DEPTH];

  logic [SAMP_W-1:0] engine_sample_q;
  sdm_pixel_t        pixel_q;
  logic              scan_q;
  logic [PIX_AW-1:0] scan_addr_q;
  logic              auto_pend_q;
  logic              auto_act_q;
  sdm_acq_t          acq_state_q;
  sdm_acq_t          acq_state_d;
  logic [ACQ_AW-1:0] wr_ptr_q;
  logic [ACQ_AW-1:0] fill_q;
  logic [ACQ_AW-1:0] fill_d;
  logic [ACQ_AW-1:0] trig_pos_q;
  logic              trig_q;
  logic [SAMP_W-1:0] acq_rd_q;

  // ----------------------------------------------------------------
  // Rasterizer decode
  // ----------------------------------------------------------------
  wire logic [ROW_W-1:0]  rast_row  = spec_bin_i.mag[MAG_W-1 -: ROW_W];
  wire logic [PIX_AW-1:0] rast_addr = {spec_bin_i.bin, rast_row};
  wire logic [CNT_W-1:0]  rast_cnt  = pix_q[rast_addr];
  // Saturating increment
  // RULE16 counter saturation
  wire logic [CNT_W-1:0]  rast_next = (rast_cnt == CNT_MAX) ? CNT_MAX
                                      : rast_cnt + 8'h01;
  // Only a real bin may pre-empt the decay of the scanned pixel
  wire logic              rast_hit  = spec_bin_i.valid && scan_q && (scan_addr_q == rast_addr);

  // ----------------------------------------------------------------
  // Display scan and persistence decode
  // ----------------------------------------------------------------
  wire logic [CNT_W-1:0] scan_cnt  = pix_q[scan_addr_q];
  wire logic [CNT_W-1:0] scan_keep = (pers_mode_i == PERS_MIN) ? CNT_ZERO
                                   : (pers_mode_i == PERS_HIGH)
                                     ? scan_cnt - (scan_cnt >> DECAY_SH)
                                     : scan_cnt;
  wire logic             scan_start = disp_ready_i && !scan_q;

  // ----------------------------------------------------------------
  // Trigger decode
  // ----------------------------------------------------------------
  wire logic [MAG_W-1:0] mask_lvl   = mask_q[spec_bin_i.bin];
  wire logic             mask_enter = (mask_lvl != MASK_RESET) && (spec_bin_i.mag > mask_lvl);
  wire logic             power_over = spec_bin_i.mag > power_thresh_i;
  wire logic             trig_raw   = spec_bin_i.valid
                                      && ((trig_mode_i == TRIG_MASK) ? mask_enter : power_over);
  // RULE17 trigger qualification
  wire logic             trig_take  = trig_raw && (acq_state_q == ACQ_ARMED);

  // ----------------------------------------------------------------
  // Autodraw decode
  // ----------------------------------------------------------------
  wire logic signed [BIN_W+1:0] auto_bin_s = $signed({2'b00, spec_bin_i.bin})
                                             + $signed({auto_freq_off_i[BIN_W], auto_freq_off_i});
  wire logic signed [MAG_W+1:0] auto_lvl_s = $signed({2'b00, spec_bin_i.mag})
                                             + $signed({auto_amp_off_i[MAG_W], auto_amp_off_i});
  wire logic        auto_bin_ok = (auto_bin_s >= 0) && (auto_bin_s < NBINS);
  wire logic [MAG_W-1:0] auto_lvl = (auto_lvl_s < 0) ? 12'h000
                                  : (auto_lvl_s > $signed({2'b00, MAG_MAX})) ? MAG_MAX
                                  : auto_lvl_s[MAG_W-1:0];
  wire logic        auto_start = auto_pend_q && spec_bin_i.valid
                                 && (spec_bin_i.bin == BIN_ZERO);
  wire logic        auto_wr    = (auto_start || auto_act_q) && spec_bin_i.valid && auto_bin_ok;

  // ----------------------------------------------------------------
  // Sample path
  // ----------------------------------------------------------------
  // RULE1 gapless sample forwarding
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      engine_sample_q <= '0;
    end else begin
      engine_sample_q <= adc_sample_i;
    end
  end

  // ----------------------------------------------------------------
  // Virtual screen
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NPIX; i++) begin
        pix_q[i] <= CNT_ZERO;
      end
    end else begin
      // RULE6 clear, RULE7 decay, RULE8 hold
      if (scan_q && !rast_hit) begin
        pix_q[scan_addr_q] <= scan_keep;
      end
      // RULE3 rasterize one pixel
      // RULE4 hit count
      // RULE2 one bin per cycle
      if (spec_bin_i.valid) begin
        pix_q[rast_addr] <= rast_next;
      end
    end
  end

  // Count to colour, blue for few, red for many
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      scan_q      <= 1'b0;
      scan_addr_q <= '0;
      pixel_q     <= '0;
    end else begin
      if (scan_start) begin
        scan_q <= 1'b1;
      end else if (scan_q && scan_addr_q == PIX_LAST) begin
        scan_q <= 1'b0;
      end
      scan_addr_q <= scan_q ? scan_addr_q + 9'h001 : '0;
      // RULE5 density colour
      pixel_q.valid        <= scan_q;
      pixel_q.addr         <= scan_addr_q;
      pixel_q.colour.red   <= scan_cnt;
      pixel_q.colour.green <= 8'h00;
      pixel_q.colour.blue  <= ~scan_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Mask memory
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NBINS; i++) begin
        mask_q[i] <= MASK_RESET;
      end
      auto_pend_q <= 1'b0;
      auto_act_q  <= 1'b0;
    end else begin
      if (mask_wr_i) begin
        mask_q[mask_bin_i] <= mask_level_i;
      end
      // RULE15 mask autodraw
      if (auto_wr) begin
        mask_q[auto_bin_s[BIN_W-1:0]] <= auto_lvl;
      end
      if (autodraw_i) begin
        auto_pend_q <= 1'b1;
      end else if (auto_start) begin
        auto_pend_q <= 1'b0;
      end
      if (auto_start && !spec_bin_i.last) begin
        auto_act_q <= 1'b1;
      end else if (spec_bin_i.valid && spec_bin_i.last) begin
        auto_act_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Acquisition control
  // ----------------------------------------------------------------
  always_comb begin
    acq_state_d = acq_state_q;
    fill_d      = fill_q;
    unique case (acq_state_q)
      ACQ_IDLE, ACQ_DONE: begin
        if (arm_i) begin
          acq_state_d = ACQ_PRE;
          fill_d      = PTR_ZERO;
        end
      end
      ACQ_PRE: begin
        fill_d = fill_q + PTR_ONE;
        if (fill_d >= pre_depth_i) begin
          acq_state_d = ACQ_ARMED;
        end
      end
      ACQ_ARMED: begin
        // RULE9 mask trigger, RULE10 masked bins only, RULE11 power trigger
        if (trig_take) begin
          acq_state_d = (post_depth_i == PTR_ZERO) ? ACQ_DONE : ACQ_POST;
          fill_d      = PTR_ZERO;
        end
      end
      ACQ_POST: begin
        // RULE14 post-trigger fill
        fill_d = fill_q + PTR_ONE;
        if (fill_d >= post_depth_i) begin
          acq_state_d = ACQ_DONE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      acq_state_q <= ACQ_IDLE;
      fill_q      <= '0;
      wr_ptr_q    <= '0;
      trig_pos_q  <= '0;
      trig_q      <= 1'b0;
      acq_rd_q    <= '0;
    end else begin
      acq_state_q <= acq_state_d;
      fill_q      <= fill_d;
      trig_q      <= trig_take;
      acq_rd_q    <= acq_q[acq_rd_addr_i];
      // RULE12 circular write
      if (acq_state_q != ACQ_DONE) begin
        acq_q[wr_ptr_q] <= adc_sample_i;
        wr_ptr_q        <= wr_ptr_q + PTR_ONE;
      end
      // RULE13 trigger position
      if (trig_take) begin
        trig_pos_q <= wr_ptr_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign engine_sample_o = engine_sample_q;
  assign pixel_o         = pixel_q;
  assign scan_busy_o     = scan_q;
  assign trig_o          = trig_q;
  assign trig_pos_o      = trig_pos_q;
  assign wr_ptr_o        = wr_ptr_q;
  assign acq_done_o      = (acq_state_q == ACQ_DONE);
  assign acq_rd_data_o   = acq_rd_q;

endmodule // sdm_density_spectrum_engine

`default_nettype wire

/* sdm_props.sv */
`timescale 1ns/1ns
`default_nettype none
module sdm_props
  import sdm_pkg::*;
(
  input wire logic              sys_clk_i,
  input wire logic              sys_rst_i,
  input wire logic [SAMP_W-1:0] adc_sample_i,
  input wire sdm_bin_t          spec_bin_i,
  input wire logic              disp_ready_i,
  input wire sdm_trig_mode_t    trig_mode_i,
  input wire logic [MAG_W-1:0]  power_thresh_i,
  input wire logic              arm_i,
  input wire logic [SAMP_W-1:0] engine_sample_o,
  input wire sdm_pixel_t        pixel_o,
  input wire logic              scan_busy_o,
  input wire logic              trig_o,
  input wire logic [ACQ_AW-1:0] trig_pos_o,
  input wire logic [ACQ_AW-1:0] wr_ptr_o,
  input wire logic              acq_done_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Length of the current run of scanned pixels
  logic [9:0] run_q;
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || !pixel_o.valid) run_q <= 10'h000;
    else run_q <= run_q + 10'h001;
  end
  a_sample_fwd: assert property (
    !$past(sys_rst_i) |-> engine_sample_o == $past(adc_sample_i)) else $error("sample lost");
  a_trig_once: assert property (trig_o |=> !trig_o)
    else $error("trigger repeated");
  a_trig_cause: assert property (trig_o |-> $past(spec_bin_i.valid))
    else $error("trigger without bin");
  a_power_level: assert property (
    trig_o && $past(trig_mode_i) == TRIG_POWER |-> $past(spec_bin_i.mag) > $past(power_thresh_i))
    else $error("power trigger below threshold");
  a_trig_pos: assert property (trig_o |-> trig_pos_o == $past(wr_ptr_o))
    else $error("trigger position wrong");
  a_ptr_step: assert property (
    !$past(sys_rst_i) && !$past(acq_done_o) |-> wr_ptr_o == $past(wr_ptr_o) + PTR_ONE)
    else $error("write pointer not stepping");
  a_done_hold: assert property (
    !$past(sys_rst_i) && $past(acq_done_o) |-> $stable(wr_ptr_o))
    else $error("write after stop");
  a_done_stays: assert property (acq_done_o && !arm_i |=> acq_done_o)
    else $error("stop state left");
  a_scan_start: assert property (disp_ready_i && !scan_busy_o |=> scan_busy_o)
    else $error("scan not started");
  a_scan_len: assert property (
    !$past(sys_rst_i) && $fell(pixel_o.valid) |-> run_q == 10'h200)
    else $error("scan length wrong");
  a_colour_map: assert property (
    pixel_o.valid |-> pixel_o.colour.green == 8'h00 && pixel_o.colour.blue == ~pixel_o.colour.red)
    else $error("colour map wrong");
  c_trig: cover property (trig_o);
  c_done: cover property ($rose(acq_done_o));
  c_scan: cover property ($fell(scan_busy_o));
endmodule // sdm_props
bind sdm_density_spectrum_engine sdm_props i_props (.sys_clk_i, .sys_rst_i, .adc_sample_i,
  .spec_bin_i, .disp_ready_i, .trig_mode_i, .power_thresh_i, .arm_i, .engine_sample_o,
  .pixel_o, .scan_busy_o, .trig_o, .trig_pos_o, .wr_ptr_o, .acq_done_o);
`default_nettype wire

/* sdm_if_frontend.sv */
`timescale 1ns/1ns
`default_nettype none
module sdm_if_frontend
  import sdm_pkg::*;
(
  input  wire logic         sys_clk_i,
  output var logic [SAMP_W-1:0] adc_sample_o
);
  // Converter runs free: a new sample every clock
  initial adc_sample_o = 16'h0000;
  always @(negedge sys_clk_i) begin
    adc_sample_o <= SAMP_W'($urandom);
  end
endmodule // sdm_if_frontend
`default_nettype wire

/* sdm_density_spectrum_engine_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module sdm_density_spectrum_engine_tb_top;
  import sdm_pkg::*;
  logic                  clk, busy, trig, done;
  logic                  rst = 1'b1, rdy = 1'b0, mwr = 1'b0, adraw = 1'b0, arm = 1'b0;
  logic [SAMP_W-1:0]     adc, esamp, rdata, m_prev, mem[ACQ_DEPTH];
  logic [MAG_W-1:0]      thr = 12'hFFF, mlvl = 12'h400;
  logic [ACQ_AW-1:0]     pre = 8'h04, post = 8'h08, rda = 8'h00, tpos, wptr;
  logic [BIN_W-1:0]      mbin = 5'h05;
  logic signed [BIN_W:0] foff = 6'sh01;
  logic signed [MAG_W:0] aoff = 13'sh0010;
  sdm_bin_t              bs = '0;
  sdm_pers_t             pers = PERS_INF;
  sdm_trig_mode_t        tm = TRIG_POWER;
  sdm_pixel_t            pix;
  int                    n_fail, num_checks, m_ptr, cnt[NPIX];
  bit                    live;
  sdm_if_frontend i_fe (.sys_clk_i(clk), .adc_sample_o(adc));
  sdm_density_spectrum_engine i_dut (.sys_clk_i(clk), .sys_rst_i(rst), .adc_sample_i(adc),
    .spec_bin_i(bs), .pers_mode_i(pers), .disp_ready_i(rdy), .trig_mode_i(tm),
    .power_thresh_i(thr), .mask_wr_i(mwr), .mask_bin_i(mbin), .mask_level_i(mlvl),
    .autodraw_i(adraw), .auto_freq_off_i(foff), .auto_amp_off_i(aoff), .arm_i(arm),
    .pre_depth_i(pre), .post_depth_i(post), .acq_rd_addr_i(rda), .engine_sample_o(esamp),
    .pixel_o(pix), .scan_busy_o(busy), .trig_o(trig), .trig_pos_o(tpos), .wr_ptr_o(wptr),
    .acq_done_o(done), .acq_rd_data_o(rdata));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Reference model of sample path and circular memory
  always @(posedge clk) begin
    live = !rst;
    m_prev = adc;
    if (rst) m_ptr = 0;
    else if (!done) begin
      mem[m_ptr] = adc;
      m_ptr = (m_ptr + 1) % ACQ_DEPTH;
    end
  end
  always @(negedge clk) begin
    if (live) begin
      chk(esamp, m_prev);
      chk(16'(wptr), 16'(m_ptr));
    end
  end
  task automatic chk(input logic [15:0] g, e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic send_bin(input int b, m);
    logic [PIX_AW-1:0] ix;
    ix = {b[BIN_W-1:0], m[MAG_W-1:MAG_W-ROW_W]};
    @(negedge clk);
    bs = '{1'b1, b == NBINS - 1, b[BIN_W-1:0], m[MAG_W-1:0]};
    if (cnt[ix] < 255) cnt[ix]++;
  endtask
  task automatic idle();
    @(negedge clk);
    bs.valid = 1'b0;
  endtask
  task automatic spectrum(input int base);
    for (int b = 0; b < NBINS; b++) send_bin(b, base ? base : $urandom);
    idle();
  endtask
  task automatic scan();
    int n;
    @(negedge clk);
    rdy = 1'b1;
    @(negedge clk);
    rdy = 1'b0;
    chk_bit(busy, 1'b1);
    n = 0;
    while (pix.valid !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    for (int i = 0; i < NPIX; i++) begin
      chk(16'(pix.addr), 16'(i));
      chk(16'(pix.colour.red), 16'(cnt[i]));
      chk(16'(pix.colour.blue), 16'(255 - cnt[i]));
      cnt[i] = pers == PERS_MIN ? 0 : pers == PERS_HIGH ? cnt[i] - cnt[i] / 4 : cnt[i];
      @(negedge clk);
    end
    chk_bit(busy, 1'b0);
  endtask
  task automatic arm_up();
    @(negedge clk);
    arm = 1'b1;
    @(negedge clk);
    arm = 1'b0;
  endtask
  task automatic try_trig(input int b, m, input logic e);
    int n;
    int p;
    send_bin(b, m);
    idle();
    p = (m_ptr + ACQ_DEPTH - 1) % ACQ_DEPTH;
    chk_bit(trig, e);
    if (e) begin
      chk(16'(tpos), 16'(p));
      n = 0;
      while (done !== 1'b1 && n < 40) begin
        @(negedge clk);
        n++;
      end
      chk(16'(n), 16'(post));
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(61));
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk_bit(done, 1'b0);
    chk_bit(busy, 1'b0);
    for (int k = 0; k < 3; k++) spectrum(0);
    for (int k = 0; k < 300; k++) send_bin(7, 12'h3A0);
    idle();
    scan();
    scan();
    pers = PERS_HIGH;
    scan();
    scan();
    pers = PERS_MIN;
    spectrum(0);
    scan();
    scan();
    $display("test persistence done");
    thr = 12'h800;
    arm_up();
    try_trig(3, 12'h900, 1'b0);
    repeat (8) @(negedge clk);
    try_trig(3, 12'h800, 1'b0);
    try_trig(3, 12'h900, 1'b1);
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      rda = 8'($urandom);
      @(negedge clk);
      chk(rdata, mem[rda]);
    end
    $display("test power trigger done");
    tm = TRIG_MASK;
    post = 8'($urandom % 16);
    mwr = 1'b1;
    @(negedge clk);
    mwr = 1'b0;
    arm_up();
    repeat (8) @(negedge clk);
    try_trig(6, 12'hF00, 1'b0);
    try_trig(5, 12'h400, 1'b0);
    try_trig(5, 12'h401, 1'b1);
    adraw = 1'b1;
    @(negedge clk);
    adraw = 1'b0;
    spectrum(12'h100);
    arm_up();
    repeat (8) @(negedge clk);
    try_trig(0, 12'hFFE, 1'b0);
    try_trig(4, 12'h110, 1'b0);
    try_trig(4, 12'h111, 1'b1);
    $display("test mask trigger done");
    close_out();
  end
  initial begin
    #1000000;
    n_fail++;
    close_out();
  end
endmodule // sdm_density_spectrum_engine_tb_top
`default_nettype wire
